/* logic/fppio_pkg.sv */
// types shared by the parallel port block
// assumes the register header sits beside it
`include "fppio_regs.svh"

package fppio_pkg;
    // ==========================================================
    // one register access from software
    typedef struct packed {
        logic [`FPPIO_ADDR_W-1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } fppio_bus_type;

    // pin override from one sharing peripheral group
    typedef struct packed {
        logic [7:0] take;
        logic [7:0] drive;
        logic [7:0] value;
    } fppio_override_type;
endpackage

/* logic/fppio_regs.svh */
// register offsets, field widths and reset values of the parallel port block
// assumes inclusion by bare name from the package and the top module
`ifndef FPPIO_REGS_SVH
`define FPPIO_REGS_SVH

// ==========================================================
// register offsets
`define FPPIO_ADDR_W 4
`define FPPIO_OFS_A_LATCH 4'h0
`define FPPIO_OFS_B_LATCH 4'h1
`define FPPIO_OFS_C_LATCH 4'h2
`define FPPIO_OFS_D_LATCH 4'h3
`define FPPIO_OFS_A_DIR 4'h4
`define FPPIO_OFS_B_DIR 4'h5
`define FPPIO_OFS_C_DIR 4'h6
`define FPPIO_OFS_D_DIR 4'h7
`define FPPIO_OFS_E_LATCH 4'h8
`define FPPIO_OFS_E_DIR 4'hc
`define FPPIO_OFS_A_PULL 4'hd
`define FPPIO_OFS_C_PULL 4'he
`define FPPIO_OFS_D_PULL 4'hf

// ==========================================================
// port widths and reset values
`define FPPIO_WIDTH_A 8
`define FPPIO_WIDTH_B 8
`define FPPIO_WIDTH_C 7
`define FPPIO_WIDTH_D 8
`define FPPIO_WIDTH_E 2
`define FPPIO_PIN_COUNT 33
`define FPPIO_RESET_DIR 8'h00
`define FPPIO_RESET_PULL 8'h00

`endif

/* logic/fppio_top.sv */
// five-port parallel io block: 33 two-way pins in ports a..e
// assumes one clock, a register port from the core, and pad cells with
// pullups outside; peripheral overrides arrive per pin, except one enable each for the serial peripheral and serial interface
// pin map of the flattened pin vectors, bit index then port bit
//   0   a0, keypad line 0
//   1   a1, keypad line 1
//   2   a2, keypad line 2
//   3   a3, keypad line 3
//   4   a4, keypad line 4
//   5   a5, keypad line 5
//   6   a6, keypad line 6
//   7   a7, keypad line 7
//   8   b0, converter channel 0
//   9   b1, converter channel 1
//   10  b2, converter channel 2
//   11  b3, converter channel 3
//   12  b4, converter channel 4
//   13  b5, converter channel 5
//   14  b6, converter channel 6
//   15  b7, converter channel 7
//   16  c0, plain port bit
//   17  c1, plain port bit
//   18  c2, plain port bit
//   19  c3, plain port bit
//   20  c4, plain port bit
//   21  c5, plain port bit
//   22  c6, plain port bit
//   23  d0, serial peripheral select
//   24  d1, serial peripheral data in
//   25  d2, serial peripheral data out
//   26  d3, serial peripheral clock
//   27  d4, timer channel 0
//   28  d5, timer channel 1
//   29  d6, timer channel 2
//   30  d7, timer channel 3
//   31  e0, serial interface transmit
//   32  e1, serial interface receive
//
// hazards for the user of this block
//   latches power up unknown: write them before setting a direction bit
//   a pin read follows its pad two to three cycles late
//   a taken pin keeps its port registers; they apply again on release
//   the keypad sees pad levels whatever the direction bit says
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "fppio_regs.svh"

module fppio_top #(
    parameter int PIN_COUNT = `FPPIO_PIN_COUNT
) (
    // clock and reset
    input wire logic CLOCK,
    input wire logic RST_N,
    // register port
    input wire logic [`FPPIO_ADDR_W-1:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    // pins, flattened a7..a0 lowest, then b, c, d, e
    input wire logic [PIN_COUNT-1:0] PIN_IN,
    output logic [PIN_COUNT-1:0] PIN_OUT,
    output logic [PIN_COUNT-1:0] PIN_OE,
    output logic [PIN_COUNT-1:0] PIN_PULLUP,
    // sharing peripheral controls
    input wire logic [7:0] KEYPAD_PIN_ENABLES,
    input wire logic [7:0] CONVERTER_PIN_TAKE,
    input wire logic SERIAL_PERIPHERAL_ENABLE,
    input wire logic [3:0] SERIAL_PERIPHERAL_OE,
    input wire logic [3:0] SERIAL_PERIPHERAL_OUT,
    input wire logic [3:0] TIMER_CHANNEL_EDGE_SELECT,
    input wire logic [3:0] TIMER_CHANNEL_OE,
    input wire logic [3:0] TIMER_CHANNEL_OUT,
    input wire logic SERIAL_INTERFACE_ENABLE,
    input wire logic SERIAL_INTERFACE_TXD,
    // pin levels seen by the peripherals
    output logic [7:0] KEYPAD_INPUT
);
    localparam int OA = 0;
    localparam int OB = OA + `FPPIO_WIDTH_A;
    localparam int OC = OB + `FPPIO_WIDTH_B;
    localparam int OD = OC + `FPPIO_WIDTH_C;
    localparam int OE = OD + `FPPIO_WIDTH_D;

    initial begin
        if (PIN_COUNT != OE + `FPPIO_WIDTH_E) begin
            $error("pin count must match the five port widths");
        end
    end

    // ==========================================================
    // reset release
    logic rst_meta;
    logic rst_sync_n;

    // two flops release the asynchronous reset
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            rst_meta <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    // ==========================================================
    // registers
    fppio_pkg::fppio_bus_type bus;
    assign bus = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

    logic [7:0] latch_a, latch_b, latch_d;
    logic [6:0] latch_c;
    logic [1:0] latch_e;
    logic [7:0] dir_a, dir_b, dir_d, pull_a, pull_d;
    logic [6:0] dir_c, pull_c;
    logic [1:0] dir_e;

    // data latches: no reset, written whatever the direction
    always_ff @(posedge CLOCK) begin
        if (bus.wr) begin
            case (bus.addr)
                `FPPIO_OFS_A_LATCH: latch_a <= bus.wdata;
                `FPPIO_OFS_B_LATCH: latch_b <= bus.wdata;
                `FPPIO_OFS_C_LATCH: latch_c <= bus.wdata[6:0];
                `FPPIO_OFS_D_LATCH: latch_d <= bus.wdata;
                `FPPIO_OFS_E_LATCH: latch_e <= bus.wdata[1:0];
                default: ;
            endcase
        end
    end

    // direction registers clear on reset
    always_ff @(posedge CLOCK or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            dir_a <= `FPPIO_RESET_DIR;
            dir_b <= `FPPIO_RESET_DIR;
            dir_c <= 7'(`FPPIO_RESET_DIR);
            dir_d <= `FPPIO_RESET_DIR;
            dir_e <= 2'(`FPPIO_RESET_DIR);
        end else if (bus.wr) begin
            case (bus.addr)
                `FPPIO_OFS_A_DIR: dir_a <= bus.wdata;
                `FPPIO_OFS_B_DIR: dir_b <= bus.wdata;
                `FPPIO_OFS_C_DIR: dir_c <= bus.wdata[6:0];
                `FPPIO_OFS_D_DIR: dir_d <= bus.wdata;
                `FPPIO_OFS_E_DIR: dir_e <= bus.wdata[1:0];
                default: ;
            endcase
        end
    end

    // pullup enables clear on reset
    always_ff @(posedge CLOCK or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pull_a <= `FPPIO_RESET_PULL;
            pull_c <= 7'(`FPPIO_RESET_PULL);
            pull_d <= `FPPIO_RESET_PULL;
        end else if (bus.wr) begin
            case (bus.addr)
                `FPPIO_OFS_A_PULL: pull_a <= bus.wdata;
                `FPPIO_OFS_C_PULL: pull_c <= bus.wdata[6:0];
                `FPPIO_OFS_D_PULL: pull_d <= bus.wdata;
                default: ;
            endcase
        end
    end

    // ==========================================================
    // pin synchronisers
    logic [PIN_COUNT-1:0] pin_meta;
    logic [PIN_COUNT-1:0] pin_sync;

    // two flops before any logic reads the pins
    always_ff @(posedge CLOCK or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pin_meta <= '0;
            pin_sync <= '0;
        end else begin
            pin_meta <= PIN_IN;
            pin_sync <= pin_meta;
        end
    end

    // ==========================================================
    // per-pin control
    logic [PIN_COUNT-1:0] latch_all, dir_all, pull_all, has_pull;
    logic [PIN_COUNT-1:0] take, per_oe, per_out;

    assign latch_all = {latch_e, latch_d, latch_c, latch_b, latch_a};
    assign dir_all = {dir_e, dir_d, dir_c, dir_b, dir_a};
    assign pull_all = {2'h0, pull_d, pull_c, 8'h00, pull_a};
    assign has_pull = {2'h0, 8'hff, 7'h7f, 8'h00, 8'hff};

    // peripheral ownership per pin; tx on e0, rx on e1
    assign take = {{2{SERIAL_INTERFACE_ENABLE}},
                   TIMER_CHANNEL_EDGE_SELECT,
                   {4{SERIAL_PERIPHERAL_ENABLE}},
                   7'h00, CONVERTER_PIN_TAKE, 8'h00};
    assign per_oe = {1'b0, SERIAL_INTERFACE_ENABLE, TIMER_CHANNEL_OE,
                     SERIAL_PERIPHERAL_OE, 7'h00, 8'h00, 8'h00};
    assign per_out = {1'b0, SERIAL_INTERFACE_TXD, TIMER_CHANNEL_OUT,
                      SERIAL_PERIPHERAL_OUT, 7'h00, 8'h00, 8'h00};

    wire logic [PIN_COUNT-1:0] next_oe;
    wire logic [PIN_COUNT-1:0] next_out;
    wire logic [PIN_COUNT-1:0] next_pull;

    genvar i;
    generate
        for (i = 0; i < PIN_COUNT; i++) begin : g_pin
            // port or peripheral drives; pullup only on port-owned inputs
            assign next_oe[i] = take[i] ? per_oe[i] : dir_all[i];
            assign next_out[i] = take[i] ? per_out[i] : latch_all[i];
            assign next_pull[i] = ~take[i] & has_pull[i] & pull_all[i] & ~dir_all[i];
        end
    endgenerate

    // pad controls from flops, one writer for each vector
    always_ff @(posedge CLOCK or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            PIN_OE <= '0;
            PIN_OUT <= '0;
            PIN_PULLUP <= '0;
        end else begin
            PIN_OE <= next_oe;
            PIN_OUT <= next_out;
            PIN_PULLUP <= next_pull;
        end
    end

    // keypad sees port a levels where enabled
    always_ff @(posedge CLOCK or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            KEYPAD_INPUT <= 8'h00;
        end else begin
            KEYPAD_INPUT <= pin_sync[OB-1:OA] & KEYPAD_PIN_ENABLES;
        end
    end

    // ==========================================================
    // read path: outputs show latch, inputs show pin
    logic [PIN_COUNT-1:0] view;
    logic [7:0] next_rdata;
    assign view = (dir_all & latch_all) | (~dir_all & pin_sync);

    always_comb begin
        next_rdata = 8'h00;
        case (bus.addr)
            `FPPIO_OFS_A_LATCH: next_rdata = view[OB-1:OA];
            `FPPIO_OFS_B_LATCH: next_rdata = view[OC-1:OB];
            `FPPIO_OFS_C_LATCH: next_rdata = {1'b0, view[OD-1:OC]};
            `FPPIO_OFS_D_LATCH: next_rdata = view[OE-1:OD];
            `FPPIO_OFS_E_LATCH: next_rdata = {6'h00, view[OE+1:OE]};
            `FPPIO_OFS_A_DIR: next_rdata = dir_a;
            `FPPIO_OFS_B_DIR: next_rdata = dir_b;
            `FPPIO_OFS_C_DIR: next_rdata = {1'b0, dir_c};
            `FPPIO_OFS_D_DIR: next_rdata = dir_d;
            `FPPIO_OFS_E_DIR: next_rdata = {6'h00, dir_e};
            `FPPIO_OFS_A_PULL: next_rdata = pull_a;
            `FPPIO_OFS_C_PULL: next_rdata = {1'b0, pull_c};
            `FPPIO_OFS_D_PULL: next_rdata = pull_d;
            default: next_rdata = 8'h00;
        endcase
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge CLOCK or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            RDATA <= 8'h00;
        end else if (bus.rd) begin
            RDATA <= next_rdata;
        end else begin
            RDATA <= 8'h00;
        end
    end
endmodule
`default_nettype wire

/* tb/five_port_parallel_io_bench.sv */
// bench of the parallel port block: registers, pins, takeovers
// assumes the checker binds itself to the top module
`timescale 1ns/1ps
`default_nettype none
module five_port_parallel_io_bench;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata, keypad_input, kbd_en = 8'h00, take = 8'h00;
    logic [32:0] pin_in, pin_out, pin_oe, pin_pu, ext_en = '0, ext_val = '0;
    logic [3:0] spi_oe = 4'h0, spi_q = 4'h0, tim_sel = 4'h0, tim_oe = 4'h0, tim_q = 4'h0;
    logic spi_en = 1'b0, sci_en = 1'b0, txd = 1'b0;
    int n_errors = 0, checks = 0, cyc = 0;
    // clock and hang guard
    always #5 clock = !clock;
    always @(posedge clock) begin
        cyc++;
        if (cyc == 2000) begin
            n_errors++;
            report_and_stop();
        end
    end
    fppio_top dut (
        .CLOCK(clock), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe),
        .PIN_PULLUP(pin_pu), .KEYPAD_PIN_ENABLES(kbd_en), .CONVERTER_PIN_TAKE(take),
        .SERIAL_PERIPHERAL_ENABLE(spi_en), .SERIAL_PERIPHERAL_OE(spi_oe),
        .SERIAL_PERIPHERAL_OUT(spi_q), .TIMER_CHANNEL_EDGE_SELECT(tim_sel),
        .TIMER_CHANNEL_OE(tim_oe), .TIMER_CHANNEL_OUT(tim_q), .SERIAL_INTERFACE_ENABLE(sci_en),
        .SERIAL_INTERFACE_TXD(txd), .KEYPAD_INPUT(keypad_input)
    );
    fppio_board board (
        .clock(clock), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pu(pin_pu),
        .ext_en(ext_en), .ext_val(ext_val), .level(pin_in)
    );
    // ==========================================================
    // shared steps
    task automatic chk(input logic [32:0] got, input logic [32:0] want);
        checks++;
        if (got !== want) begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, want);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        {wr, addr, wdata} <= {1'b1, a, d};
        @(posedge clock);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a, input logic [7:0] e);
        @(posedge clock);
        {rd, addr} <= {1'b1, a};
        @(posedge clock);
        rd <= 1'b0;
        #1 chk(33'(rdata), 33'(e));
    endtask
    task automatic settle;
        repeat (4) @(posedge clock);
        #1;
    endtask
    task automatic report_and_stop;
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // ==========================================================
    // scenarios
    task automatic t_regs;
        logic [3:0] ofs [8] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'hc, 4'hd, 4'he, 4'hf};
        logic [7:0] msk [8] = '{8'hff, 8'hff, 8'h7f, 8'hff, 8'h03, 8'hff, 8'h7f, 8'hff};
        for (int i = 0; i < 8; i++) begin
            rd_reg(ofs[i], 8'h00);
            wr_reg(ofs[i], 8'hff);
            rd_reg(ofs[i], msk[i]);
        end
        wr_reg(4'h9, 8'hff);
        rd_reg(4'h9, 8'h00);
    endtask
    task automatic t_out;
        logic [3:0] ofs [5] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h8};
        logic [7:0] e [5] = '{8'ha5, 8'ha5, 8'h25, 8'ha5, 8'h01};
        for (int i = 0; i < 5; i++) wr_reg(ofs[i], 8'ha5);
        kbd_en <= 8'hff;
        for (int i = 0; i < 5; i++) rd_reg(ofs[i], e[i]);
        settle();
        chk(pin_oe, {33{1'b1}});
        chk(pin_out, {2'h1, 8'ha5, 7'h25, 8'ha5, 8'ha5});
        chk(pin_pu, 33'h0);
        chk(33'(keypad_input), 33'ha5);
    endtask
    task automatic t_in;
        wr_reg(4'h5, 8'h00);
        wr_reg(4'h1, 8'hff);
        {ext_en[15:8], ext_val[15:8]} <= {8'hff, 8'h3c};
        settle();
        chk(33'(pin_oe[15:8]), 33'h0);
        rd_reg(4'h1, 8'h3c);
        wr_reg(4'h5, 8'hff);
        ext_en <= '0;
        settle();
        rd_reg(4'h1, 8'hff);
    endtask
    task automatic t_pull;
        wr_reg(4'h6, 8'h00);
        wr_reg(4'h4, 8'h00);
        kbd_en <= 8'h0f;
        settle();
        chk(33'(pin_pu[22:16]), 33'h7f);
        rd_reg(4'h2, 8'h7f);
        chk(33'(keypad_input), 33'h0f);
        wr_reg(4'h6, 8'h7f);
        settle();
        chk(33'(pin_pu[22:16]), 33'h0);
    endtask
    task automatic t_take;
        wr_reg(4'h7, 8'h00);
        wr_reg(4'hc, 8'h00);
        {take, spi_en, sci_en, txd} <= {8'hff, 3'h7};
        {spi_oe, spi_q, tim_sel, tim_oe, tim_q} <= {4'hf, 4'h5, 4'hf, 4'hf, 4'ha};
        settle();
        chk(33'(pin_oe[15:8]), 33'h0);
        chk(33'(pin_oe[32:23]), 33'h1ff);
        chk(33'(pin_out[31:23]), 33'h1a5);
    endtask
    task automatic t_keep;
        @(posedge clock);
        {rst_n, take, spi_en, sci_en, tim_sel} <= '0;
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        repeat (3) @(posedge clock);
        rd_reg(4'h4, 8'h00);
        rd_reg(4'hd, 8'h00);
        wr_reg(4'h4, 8'hff);
        rd_reg(4'h0, 8'ha5);
    endtask
    initial begin
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        repeat (3) @(posedge clock);
        t_regs();
        t_out();
        t_in();
        t_pull();
        t_take();
        t_keep();
        report_and_stop();
    end
endmodule
`default_nettype wire

/* tb/fppio_board.sv */
// board around the pads: external drivers, pullups, floating pins
// assumes pad outputs of the block and drive requests from the bench
`timescale 1ns/1ps
`default_nettype none
module fppio_board (
    // pattern clock
    input wire logic clock,
    // pads and board drivers
    input wire logic [32:0] pin_out,
    input wire logic [32:0] pin_oe,
    input wire logic [32:0] pin_pu,
    input wire logic [32:0] ext_en,
    input wire logic [32:0] ext_val,
    // resolved levels
    output logic [32:0] level
);
    logic flip = 1'b0;
    // a floating pin wanders each cycle
    always @(posedge clock) flip <= !flip;
    // block, then board driver, then pullup
    always_comb begin
        for (int i = 0; i < 33; i++) begin
            level[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_val[i] : pin_pu[i] | flip;
        end
    end
endmodule
`default_nettype wire

/* tb/fppio_chk.sv */
// checker of the parallel port block on the top module ports
// assumes one clock domain and the bind at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module fppio_chk #(
    parameter int PIN_COUNT = 33
) (
    // clock, reset, register port
    input wire logic CLOCK,
    input wire logic RST_N,
    input wire logic [3:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [7:0] RDATA,
    // pins and takeover
    input wire logic [PIN_COUNT-1:0] PIN_OE,
    input wire logic [PIN_COUNT-1:0] PIN_PULLUP,
    input wire logic [7:0] CONVERTER_PIN_TAKE
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RST_N);
    // ==========================================================
    // direction write of port a
    sequence dir_a_write;
        WR && ADDR == 4'h4;
    endsequence
    // ==========================================================
    // assertions
    reset_clear_a: assert property (disable iff (1'b0) !RST_N |-> !PIN_OE && !PIN_PULLUP)
        else $error("pins active in reset");
    dir_drive_a: assert property (dir_a_write |-> ##2 PIN_OE[7:0] == $past(WDATA, 2))
        else $error("port a drive wrong");
    unmapped_read_a: assert property (RD && ADDR inside {4'h9, 4'ha, 4'hb} |=> !RDATA)
        else $error("hole reads nonzero");
    c_top_zero_a: assert property (RD && ADDR inside {4'h2, 4'h6, 4'he} |=> !RDATA[7])
        else $error("port c bit 7 set");
    e_upper_zero_a: assert property (RD && ADDR inside {4'h8, 4'hc} |=> !RDATA[7:2])
        else $error("port e upper set");
    pullup_off_a: assert property (!(PIN_PULLUP & PIN_OE))
        else $error("pullup on output");
    no_pullup_be_a: assert property (!PIN_PULLUP[15:8] && !PIN_PULLUP[32:31])
        else $error("pullup on b or e");
    converter_take_a: assert property ((CONVERTER_PIN_TAKE == 8'hff)[*2] |-> !PIN_OE[15:8])
        else $error("taken pin driven");
endmodule
bind fppio_top fppio_chk #(.PIN_COUNT(PIN_COUNT)) u_chk (
    .CLOCK, .RST_N, .ADDR, .WDATA, .WR, .RD, .RDATA, .PIN_OE, .PIN_PULLUP, .CONVERTER_PIN_TAKE
);
`default_nettype wire
